/* File: common/psc_pkg.sv */
// package: constants and types for the pipelined burst sram cycle control
package psc_pkg;

    // ********************************************
    // widths and sizes
    // ********************************************
    localparam int ADDR_W    = 17;
    localparam int BYTES     = 4;
    localparam int BYTE_W    = 8;
    localparam int DATA_W    = BYTES * BYTE_W;
    localparam int WORD_W    = DATA_W + BYTES;
    localparam int BURST_W   = 2;
    localparam int BUF_DEPTH = 2;

    // ********************************************
    // values after reset, and the burst counter step
    // ********************************************
    localparam logic [BURST_W-1:0] CNT_RST   = 2'h0;
    localparam logic [BURST_W-1:0] CNT_STEP  = 2'h1;
    localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
    localparam logic [BYTES-1:0]   PAR_RST   = 4'h0;
    localparam logic [BYTES-1:0]   LANES_OFF = 4'h0;

    // operation held in the first and second pipeline stages
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } psc_op_e;

endpackage

/* File: design/psc_buf.sv */
// two-entry buffer with valid/ready on both sides and pass-through when empty
module psc_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = psc_pkg::BUF_DEPTH
) (
    input  wire logic             clk_i,     // clock
    input  wire logic             rst_n_i,   // async reset, active low
    input  wire logic             in_valid_i, // word offered
    output logic                  in_ready_o, // room for a word
    input  wire logic [WIDTH-1:0] in_data_i, // word in
    output logic                  out_valid_o, // word available
    input  wire logic             out_ready_i, // sink takes word
    output logic [WIDTH-1:0]      out_data_o // word out
);
    import psc_pkg::*;

    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [PTR_W-1:0]            rd;
        logic [PTR_W-1:0]            wr;
        logic [CNT_W-1:0]            cnt;
    } psc_buf_s;

    psc_buf_s s;
    psc_buf_s next_s;
    logic     push;
    logic     pop;
    logic     bypass;

    assign in_ready_o  = s.cnt < CNT_W'(DEPTH);
    assign out_valid_o = (s.cnt != '0) || in_valid_i;
    assign out_data_o  = (s.cnt != '0) ? s.slot[s.rd] : in_data_i;

    // ********************************************
    // pointer and occupancy update
    // ********************************************
    always_comb begin
        next_s = s;
        bypass = (s.cnt == '0) && out_ready_i;
        push   = in_valid_i && in_ready_o && !bypass;
        pop    = out_ready_i && (s.cnt != '0);
        if (push) begin
            next_s.slot[s.wr] = in_data_i;
            next_s.wr = (s.wr == PTR_W'(DEPTH - 1)) ? '0 : s.wr + PTR_W'(1);
        end
        if (pop) begin
            next_s.rd = (s.rd == PTR_W'(DEPTH - 1)) ? '0 : s.rd + PTR_W'(1);
        end
        next_s.cnt = s.cnt + CNT_W'(push) - CNT_W'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

/* File: design/psc_sram.sv */
// pipelined burst sram: cycle control, burst counter, byte lanes, output drive
module psc_sram #(
    parameter int ADDR_W = psc_pkg::ADDR_W
) (
    input  wire logic                        clk_i,          // clock
    input  wire logic                        rst_n_i,        // async reset, active low
    input  wire logic [ADDR_W-1:0]           addr_i,         // external address
    input  wire logic                        read_write_n_i, // high read, low write
    input  wire logic                        advance_not_load_i, // high advance, low load
    input  wire logic                        chip_select_first_n_i, // first enable, low
    input  wire logic                        chip_select_second_n_i, // second enable, low
    input  wire logic                        chip_select_third_i, // third enable, high
    input  wire logic                        clk_enable_n_i, // edge used when low
    input  wire logic                        byte0_write_n_i, // lane 0 write, low
    input  wire logic                        byte1_write_n_i, // lane 1 write, low
    input  wire logic                        byte2_write_n_i, // lane 2 write, low
    input  wire logic                        byte3_write_n_i, // lane 3 write, low
    input  wire logic                        output_enable_n_i, // async output enable
    input  wire logic                        standby_request_i, // async standby
    input  wire logic                        burst_order_i,  // high interleaved
    input  wire logic [psc_pkg::DATA_W-1:0]  data_i,         // data pins in
    input  wire logic [psc_pkg::BYTES-1:0]   parity_i,       // parity pins in
    output logic [psc_pkg::DATA_W-1:0]       data_o,         // data pins out
    output logic [psc_pkg::BYTES-1:0]        parity_o,       // parity pins out
    output logic                             data_oe_o,      // drive data and parity
    output logic                             power_down_o    // deselected or standby
);
    import psc_pkg::*;

    localparam int BUF_W = ADDR_W + BYTES + WORD_W;

    // ********************************************
    // state
    // ********************************************
    typedef struct packed {
        logic                active;
        logic                burst_write;
        logic [ADDR_W-1:0]   base;
        logic [BURST_W-1:0]  cnt;
        psc_op_e             p1_op;
        logic [ADDR_W-1:0]   p1_addr;
        logic [BYTES-1:0]    p1_lanes;
        psc_op_e             p2_op;
        logic [ADDR_W-1:0]   p2_addr;
        logic [BYTES-1:0]    p2_lanes;
        logic                drive;
        logic [DATA_W-1:0]   q;
        logic [BYTES-1:0]    qp;
    } psc_sram_s;

    psc_sram_s            s;
    psc_sram_s            next_s;
    logic [WORD_W-1:0]    mem [2**ADDR_W];
    logic [WORD_W-1:0]    rd_word;
    logic                 take;
    logic                 sel;
    logic                 cmd_load;
    logic [BYTES-1:0]     lanes;
    logic [BURST_W-1:0]   next_cnt;
    logic [BURST_W-1:0]   low_bits;
    logic                 buf_in_valid;
    logic                 buf_in_ready;
    logic [BUF_W-1:0]     buf_in_data;
    logic                 buf_out_valid;
    logic                 buf_out_ready;
    logic [BUF_W-1:0]     buf_out_data;
    logic [ADDR_W-1:0]    wr_addr;
    logic [BYTES-1:0]     wr_lanes;
    logic [WORD_W-1:0]    wr_word;

    // ********************************************
    // input decode
    // ********************************************
    // standby freezes every register; edge suppression freezes all but the write buffer and array
    assign take     = !clk_enable_n_i && !standby_request_i;
    assign sel      = !chip_select_first_n_i && !chip_select_second_n_i
                      && chip_select_third_i;
    assign cmd_load = !advance_not_load_i;
    assign lanes    = ~{byte3_write_n_i, byte2_write_n_i,
                        byte1_write_n_i, byte0_write_n_i};
    assign next_cnt = s.cnt + CNT_STEP;
    // order pin is read live, open pin reads high as interleaved
    assign low_bits = burst_order_i ? (s.base[1:0] ^ next_cnt)
                                    : (s.base[1:0] + next_cnt);
    assign rd_word  = mem[s.p2_addr];

    // ********************************************
    // cycle control
    // ********************************************
    always_comb begin
        next_s = s;
        if (take) begin
            // third stage: read data out two edges after the command
            next_s.drive = (s.p2_op == OP_READ);
            if (s.p2_op == OP_READ) begin
                next_s.q  = rd_word[DATA_W-1:0];
                next_s.qp = rd_word[WORD_W-1:DATA_W];
            end
            // second stage: command waits one edge for its data slot
            next_s.p2_op    = s.p1_op;
            next_s.p2_addr  = s.p1_addr;
            next_s.p2_lanes = s.p1_lanes;
            // first stage: command decode
            next_s.p1_lanes = lanes;
            if (cmd_load) begin
                if (sel) begin
                    next_s.active      = 1'b1;
                    next_s.burst_write = !read_write_n_i;
                    next_s.base        = addr_i;
                    next_s.cnt         = CNT_RST;
                    next_s.p1_addr     = addr_i;
                    next_s.p1_op       = read_write_n_i ? OP_READ : OP_WRITE;
                end else begin
                    next_s.active = 1'b0;
                    next_s.p1_op  = OP_IDLE;
                end
            end else if (s.active) begin
                next_s.cnt     = next_cnt;
                next_s.p1_addr = {s.base[ADDR_W-1:2], low_bits};
                next_s.p1_op   = s.burst_write ? OP_WRITE : OP_READ;
            end else begin
                next_s.p1_op = OP_IDLE;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s.active      <= 1'b0;
            s.burst_write <= 1'b0;
            s.base        <= '0;
            s.cnt         <= CNT_RST;
            s.p1_op       <= OP_IDLE;
            s.p1_addr     <= '0;
            s.p1_lanes    <= LANES_OFF;
            s.p2_op       <= OP_IDLE;
            s.p2_addr     <= '0;
            s.p2_lanes    <= LANES_OFF;
            s.drive       <= 1'b0;
            s.q           <= DATA_RST;
            s.qp          <= PAR_RST;
        end else begin
            s <= next_s;
        end
    end

    // ********************************************
    // write path through the buffer
    // ********************************************
    // write with no lane enabled is dropped here
    // data pins are taken at the second enabled edge after the command
    assign buf_in_valid  = take && (s.p2_op == OP_WRITE)
                           && (s.p2_lanes != LANES_OFF) && buf_in_ready;
    assign buf_in_data   = {s.p2_addr, s.p2_lanes, parity_i, data_i};
    // array writes stall in standby; pipeline is frozen meanwhile
    assign buf_out_ready = !standby_request_i;
    assign {wr_addr, wr_lanes, wr_word} = buf_out_data;

    psc_buf #(
        .WIDTH (BUF_W),
        .DEPTH (BUF_DEPTH)
    ) psc_buf_inst (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_data),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );

    always_ff @(posedge clk_i) begin
        if (buf_out_valid && buf_out_ready) begin
            for (int i = 0; i < BYTES; i++) begin
                if (wr_lanes[i]) begin
                    mem[wr_addr][i*BYTE_W +: BYTE_W] <= wr_word[i*BYTE_W +: BYTE_W];
                    mem[wr_addr][DATA_W + i]         <= wr_word[DATA_W + i];
                end
            end
        end
    end

    // ********************************************
    // pins
    // ********************************************
    assign data_o       = s.q;
    assign parity_o     = s.qp;
    // async gating by output enable and standby
    assign data_oe_o    = s.drive && !output_enable_n_i && !standby_request_i;
    assign power_down_o = standby_request_i || !s.active;

    // ********************************************
    // assertions
    // ********************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    read_lat_a: assert property (
        take && cmd_load && sel && read_write_n_i ##1 take ##1 take |=> s.drive)
        else $error("read data not driven two edges after command");

    write_float_a: assert property (
        take && cmd_load && sel && !read_write_n_i ##1 take ##1 take |=> !data_oe_o)
        else $error("driver on during write data cycle");

    desel_float_a: assert property (
        take && cmd_load && !sel ##1 take ##1 take |=> !data_oe_o)
        else $error("data lines driven after deselect");

    edge_hold_a: assert property (
        clk_enable_n_i |=> $stable(s.q) && $stable(s.drive) && $stable(s.cnt))
        else $error("state changed on suppressed edge");

    burst_step_a: assert property (
        take && !cmd_load && s.active |=> s.cnt == $past(next_cnt))
        else $error("burst counter did not step by one");

    burst_type_a: assert property (
        take && !cmd_load && s.active && s.burst_write |=> s.p1_op == OP_WRITE)
        else $error("write burst continued as another type");

    cont_desel_a: assert property (
        take && !cmd_load && !s.active ##1 take ##1 take |=> !s.drive)
        else $error("continue deselect started an access");

    cont_nop_a: assert property (
        take && !cmd_load && !s.active |=> s.p1_op == OP_IDLE)
        else $error("continue deselect queued an operation");

    oe_gate_a: assert property (
        output_enable_n_i || standby_request_i |-> !data_oe_o)
        else $error("driver on while output enable high");

    standby_freeze_a: assert property (
        standby_request_i |=> $stable(s.p1_op) && $stable(s.base))
        else $error("inputs taken during standby");

    abort_write_a: assert property (
        take && s.p2_op == OP_WRITE && s.p2_lanes == LANES_OFF |-> !buf_in_valid)
        else $error("aborted write reached the array");

    write_lat_a: assert property (
        take && cmd_load && sel && !read_write_n_i && lanes != LANES_OFF
        ##1 take ##1 take |-> buf_in_valid)
        else $error("write data not taken two edges after command");

    write_oe_a: assert property (
        take && s.p2_op == OP_WRITE |=> !s.drive)
        else $error("driver set for a write data cycle");

    interleave_a: assert property (
        take && !cmd_load && s.active && burst_order_i
        |=> s.p1_addr[1:0] == ($past(s.base[1:0]) ^ s.cnt))
        else $error("interleaved burst address wrong");

    linear_a: assert property (
        take && !cmd_load && s.active && !burst_order_i
        |=> s.p1_addr[1:0] == 2'($past(s.base[1:0]) + s.cnt))
        else $error("linear burst address wrong");

    burst_wrap_a: assert property (
        take && !cmd_load && s.active && s.cnt == 2'h3 |=> s.cnt == CNT_RST)
        else $error("burst counter did not wrap after four");

    load_base_a: assert property (
        take && cmd_load && sel |=> s.cnt == CNT_RST && s.base == $past(addr_i))
        else $error("load did not take the external address");

    desel_pdown_a: assert property (
        take && cmd_load && !sel |=> power_down_o)
        else $error("deselected device not powered down");

    read_burst_c: cover property (
        take && cmd_load && sel && read_write_n_i ##1 take && !cmd_load [*3]);
    write_burst_c: cover property (
        take && cmd_load && sel && !read_write_n_i ##1 take && !cmd_load [*3]);
    suspend_c: cover property (s.drive && clk_enable_n_i [*2]);
    standby_c: cover property (standby_request_i ##1 !standby_request_i);

endmodule

/* File: test/psc_ctrl_model.sv */
// controller-side write data model for the burst sram bench
module psc_ctrl_model (
    input  wire logic        clk_i,    // clock
    input  wire logic        step_i,   // edge used by the sram
    input  wire logic        wr_cmd_i, // write command at this edge
    input  wire logic [35:0] word_i,   // parity and data for it
    output logic [31:0]      data_o,   // to data pins
    output logic [3:0]       parity_o  // to parity pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // two-stage delay of write words
    // ****************************************
    logic [36:0] stage1 = '0;
    logic [36:0] stage2 = '0;
    logic [35:0] bus    = '0;
    always @(posedge clk_i) begin
        if (step_i) begin
            stage2 <= stage1;
            stage1 <= {wr_cmd_i, word_i};
        end
    end
    // word on pins two used edges after command; released bus toggles
    always @(negedge clk_i) begin
        bus <= stage2[36] ? stage2[35:0] : ~bus;
    end
    assign {parity_o, data_o} = bus;
endmodule

/* File: test/psc_sram_test.sv */
// self-checking bench for the burst sram cycle control
module psc_sram_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // pins, model state and counters
    // ****************************************
    logic        clk_i = 0, rst_n_i = 0, rw_n = 1, adv = 0, cs1_n = 1, cs2_n = 0, cs3 = 1;
    logic        cke_n = 0, oe_n = 0, sby = 0, order = 1, brd = 0, bact = 0, wr = 0;
    logic        rdk = 0, oe, pdn;
    logic [16:0] addr = '0, base = '0;
    logic [3:0]  bw_n = 4'hf, par_i, par_o;
    logic [31:0] dat_i, dat_o;
    logic [35:0] word = '0, exp = '0;
    logic [1:0]  cnt = '0;
    logic [37:0] q1 = '0, q2 = '0, q3 = '0;
    logic [35:0] mem [logic [16:0]];
    int          fails = 0, checked = 0;

    always #5 clk_i = ~clk_i;

    psc_sram psc_sram_inst (
        .clk_i, .rst_n_i, .addr_i(addr), .read_write_n_i(rw_n), .advance_not_load_i(adv),
        .chip_select_first_n_i(cs1_n), .chip_select_second_n_i(cs2_n),
        .chip_select_third_i(cs3), .clk_enable_n_i(cke_n), .byte0_write_n_i(bw_n[0]),
        .byte1_write_n_i(bw_n[1]), .byte2_write_n_i(bw_n[2]), .byte3_write_n_i(bw_n[3]),
        .output_enable_n_i(oe_n), .standby_request_i(sby), .burst_order_i(order),
        .data_i(dat_i), .parity_i(par_i), .data_o(dat_o), .parity_o(par_o),
        .data_oe_o(oe), .power_down_o(pdn));
    psc_ctrl_model psc_ctrl_model_inst (.clk_i, .step_i(!cke_n && !sby), .wr_cmd_i(wr),
        .word_i(word), .data_o(dat_i), .parity_o(par_i));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %0t ns: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // outputs seen just before each edge, against commands one (power down) and three (drive, data) used edges back
    always @(posedge clk_i) begin
        if (rst_n_i) begin
            chk(36'(oe), 36'(q3[36] && !oe_n && !sby));
            chk(36'(pdn), 36'(!q1[37] || sby));
            if (q3[36] && !oe_n && !sby)
                chk({par_o, dat_o}, q3[35:0]);
        end
        if (!cke_n && !sby) begin
            q3 <= q2;
            q2 <= q1;
            q1 <= {bact, rdk, exp};
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    // k: 0 load read, 1 load write, 2 continue, 3..5 deselect by one select
    task automatic op(input int k, input logic [16:0] a, input logic [3:0] ln,
                      input logic [35:0] w);
        logic [16:0] ea;
        @(negedge clk_i);
        {cke_n, sby, adv, addr, bw_n, word} = {2'b00, k == 2, a, ln, w};
        {cs1_n, cs2_n, cs3} = {k == 3, k == 4, k != 5};
        rw_n = (k == 2) ? !brd : (k != 1);
        if (k < 2)
            {base, cnt, brd, bact} = {a, 2'h0, k == 0, 1'b1};
        else if (k == 2)
            cnt = cnt + 2'h1;
        else
            bact = 0;
        ea = {base[16:2], order ? base[1:0] ^ cnt : base[1:0] + cnt};
        rdk = bact && brd;
        wr = bact && !brd;
        exp = mem.exists(ea) ? mem[ea] : '0;
        if (wr) begin
            for (int i = 0; i < 4; i++)
                if (!ln[i])
                    {exp[32+i], exp[8*i+:8]} = {w[32+i], w[8*i+:8]};
            mem[ea] = exp;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) op(3, 17'h0, 4'hf, '0);
    endtask

    task automatic hold(input int n);
        @(negedge clk_i);
        cke_n = 1;
        repeat (n - 1) @(negedge clk_i);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_bursts();
        order = 1;
        for (int i = 0; i < 4; i++)
            op(i == 0 ? 1 : 2, 17'h5, 4'h0, 36'(i + 1) * 36'h1_1111_1111);
        for (int i = 0; i < 5; i++)
            op(i == 0 ? 0 : 2, 17'h5, 4'h0, '0);
        idle(1);
        order = 0;
        for (int i = 0; i < 4; i++)
            op(i == 0 ? 0 : 2, 17'h6, 4'h0, '0);
        idle(3);
    endtask

    task automatic t_lanes();
        order = 1;
        op(1, 17'h8, 4'h0, 36'h1_1111_1111);
        op(1, 17'h8, 4'ha, 36'h2_2222_2222);
        op(1, 17'h8, 4'hf, 36'h3_3333_3333);
        op(0, 17'h8, 4'hf, '0);
        idle(4);
        oe_n = 1;
        for (int i = 0; i < 4; i++)
            op(i == 0 ? 0 : 2, 17'h4, 4'hf, '0);
        idle(3);
        oe_n = 0;
        idle(3);
    endtask

    task automatic t_select();
        for (int k = 3; k < 6; k++) begin
            op(0, 17'h8, 4'hf, '0);
            op(k, 17'h8, 4'hf, '0);
            op(2, 17'h8, 4'hf, '0);
        end
        idle(3);
    endtask

    task automatic t_hold();
        for (int i = 0; i < 4; i++)
            op(i == 0 ? 0 : 2, 17'h4, 4'hf, '0);
        hold(3);
        op(1, 17'h9, 4'h0, 36'h4_4444_4444);
        op(2, 17'h9, 4'h0, 36'h5_5555_5555);
        op(2, 17'h9, 4'h0, 36'h6_6666_6666);
        hold(2);
        op(0, 17'h9, 4'hf, '0);
        op(2, 17'h9, 4'hf, '0);
        op(2, 17'h9, 4'hf, '0);
        idle(3);
    endtask

    task automatic t_snooze();
        op(1, 17'hc, 4'h0, 36'h7_7777_7777);
        idle(2);
        @(negedge clk_i);
        {sby, adv, cs1_n, rw_n} = 4'b1001;
        repeat (3) @(negedge clk_i);
        op(0, 17'hc, 4'hf, '0);
        idle(3);
    endtask

    initial begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1;
        t_bursts();
        t_lanes();
        t_select();
        t_hold();
        t_snooze();
        report_and_stop();
    end

    initial begin
        #20000;
        fails++;
        report_and_stop();
    end
endmodule
